// ===== common/bsbe_defs.vh
// Constants for the blind status byte encoder
`ifndef BSBE_DEFS_VH
`define BSBE_DEFS_VH
`define BSBE_ADDR_STATE 8'h00
`define BSBE_ADDR_CTRL 8'h04
`define BSBE_ADDR_SEND 8'h08
`define BSBE_BIT_SAFE_A 5
`define BSBE_BIT_SAFE_B 4
`define BSBE_BIT_AUTO 3
`define BSBE_BIT_SUN 2
`define BSBE_POS_BETWEEN 2'b00
`define BSBE_POS_LOWER 2'b01
`define BSBE_POS_UPPER 2'b10
`define BSBE_POS_UNKNOWN 2'b11
`define BSBE_STATE_RST 8'h03
`define BSBE_CTRL_RST 1'b1
`define BSBE_ADDR_W 8
`endif

// ===== logic/bsbe_mode_pick.v
// Priority selector keeping at most one operating mode active
`timescale 1ns/100ps
`default_nettype none
module bsbe_mode_pick (
  input wire [3:0] req,
  output reg [3:0] grant
);
  // Highest bit wins; safety A outranks all others
  always @* begin
    grant = 4'h0;
    if (req[3]) begin
      grant = 4'h8;
    end else if (req[2]) begin
      grant = 4'h4;
    end else if (req[1]) begin
      grant = 4'h2;
    end else if (req[0]) begin
      grant = 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== logic/bsbe_top.v
// Blind channel status byte encoder with AHB-Lite register access
//
// Summary of operation
// - Channel state and operating condition reported as one byte.
// - Status byte identifies the mode the channel currently runs in.
// - At most one operating mode indication is active at once.
// - Status byte is sent on the bus whenever any bit changes.
// - Bits 1:0: 00 between, 01 lower, 10 upper, 11 unknown.
//
// Status path: inputs -> state_r -> tx_byte/tx_req, two clocks.
// tx_req stays high until tx_ack; tx_byte is stable meanwhile.
// Mode inputs are resolved by priority A, B, automatic, sun.
// Both end inputs high, or position not known, give code 11.
// A change seen while sending is disabled goes out on re-enable.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "bsbe_defs.vh"
module bsbe_top (
  input wire clk,
  input wire nrst,
  // Channel mode levels from the movement logic
  input wire mode_safe_a,
  input wire mode_safe_b,
  input wire mode_auto,
  input wire mode_sun,
  // End position levels
  input wire at_upper,
  input wire at_lower,
  input wire pos_known,
  // Handshake towards the building bus sender
  input wire tx_ack,
  output reg tx_req,
  output reg [7:0] tx_byte,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata
);
  // Status byte pipeline
  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [7:0] sent_r;
  reg send_en_r;
  reg force_r;
  // Register bus capture
  reg ap_wr_r;
  reg [7:0] ap_addr_r;
  wire [3:0] grant;
  reg [1:0] pos_code;
  wire ap_valid;
  reg [31:0] rd_word_nxt;
  wire wr_ctrl;
  wire wr_send;
  // Send decision terms
  wire byte_changed;
  wire tx_slot_free;
  wire tx_load;

  bsbe_mode_pick u_pick (
    .req({mode_safe_a, mode_safe_b, mode_auto, mode_sun}),
    .grant(grant)
  );

  always @* begin
    if (!pos_known || (at_upper && at_lower)) begin
      pos_code = `BSBE_POS_UNKNOWN;
    end else if (at_upper) begin
      pos_code = `BSBE_POS_UPPER;
    end else if (at_lower) begin
      pos_code = `BSBE_POS_LOWER;
    end else begin
      pos_code = `BSBE_POS_BETWEEN;
    end
  end

  always @* begin
    state_nxt = 8'h00;
    state_nxt[`BSBE_BIT_SAFE_A] = grant[3];
    state_nxt[`BSBE_BIT_SAFE_B] = grant[2];
    state_nxt[`BSBE_BIT_AUTO] = grant[1];
    state_nxt[`BSBE_BIT_SUN] = grant[0];
    state_nxt[1:0] = pos_code;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state_r <= `BSBE_STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Register map, one aligned word each:
  //   0x00 status byte, read only, bits 7..6 read as zero
  //   0x04 bit 0 send enable, set after reset
  //   0x08 write bit 0 high to resend; read bit 0 is the pending flag
  // Unmapped offsets read zero and ignore writes, always OKAY
  // Only the low address byte is decoded, so the map aliases upward

  // Address phase is taken when selected, ready and NONSEQ or SEQ
  assign ap_valid = hsel && hready && htrans[1];

  // Address phase capture; writes land one cycle later
  always @(posedge clk) begin
    if (!nrst) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready) begin
      ap_wr_r <= ap_valid && hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  // Write strobes, valid in the data phase while hwdata stands
  assign wr_ctrl = ap_wr_r && (ap_addr_r == `BSBE_ADDR_CTRL);
  assign wr_send = ap_wr_r && (ap_addr_r == `BSBE_ADDR_SEND);

  // Read word chosen in the address phase
  always @* begin
    rd_word_nxt = 32'h0000_0000;
    case (haddr[7:0])
      `BSBE_ADDR_STATE: begin
        rd_word_nxt = {24'h00_0000, state_r};
      end
      `BSBE_ADDR_CTRL: begin
        rd_word_nxt = {31'h0000_0000, send_en_r};
      end
      `BSBE_ADDR_SEND: begin
        rd_word_nxt = {31'h0000_0000, tx_req};
      end
      default: begin
        rd_word_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at the address phase; zero-wait slave
  // hrdata holds until the next read so a slow master still sees it
  always @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_word_nxt;
    end
  end

  // Never stretches or errors; kept registered for clean outputs
  always @(posedge clk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Send enable; a disabled channel still tracks its state
  always @(posedge clk) begin
    if (!nrst) begin
      send_en_r <= `BSBE_CTRL_RST;
    end else if (wr_ctrl) begin
      send_en_r <= hwdata[0];
    end
  end

  // Forced resend, a one-cycle pulse per write of a one
  always @(posedge clk) begin
    if (!nrst) begin
      force_r <= 1'b0;
    end else begin
      force_r <= wr_send && hwdata[0];
    end
  end

  // any bit differing from the last byte handed over
  assign byte_changed = (state_r != sent_r);

  // Slot is free when idle or when the bus takes the byte now
  assign tx_slot_free = !tx_req || tx_ack;

  // Disabled sending defers a change rather than dropping it
  assign tx_load = send_en_r && (byte_changed || force_r) && tx_slot_free;

  // send on change; new change wins over ack
  // Holding the byte until ack avoids tearing a frame mid-send
  always @(posedge clk) begin
    if (!nrst) begin
      tx_req <= 1'b0;
      tx_byte <= 8'h00;
      sent_r <= 8'h00;
    end else if (tx_load) begin
      tx_req <= 1'b1;
      tx_byte <= state_r;
      sent_r <= state_r;
    end else if (tx_ack) begin
      tx_req <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/bsbe_assertions.sv
// Checker on the status byte outputs and the AHB-Lite response outputs
`timescale 1ns/100ps
`default_nettype none
module bsbe_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mode_safe_a,
  input wire logic at_upper,
  input wire logic at_lower,
  input wire logic pos_known,
  input wire logic tx_ack,
  input wire logic tx_req,
  input wire logic [7:0] tx_byte,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_high_zero: assert property (tx_byte[7:6] == 2'b00)
    else $error("spare bits set");
  a_one_mode: assert property ($onehot0(tx_byte[5:2]))
    else $error("two modes");
  a_held_byte: assert property (tx_req && !tx_ack |=>
    tx_req && $stable(tx_byte)) else $error("byte lost");
  a_mode_sent: assert property ($rose(mode_safe_a) && !tx_req |->
    ##[1:2] tx_req && tx_byte[5]) else $error("mode not sent");
  a_lower_code: assert property ($rose(at_lower) && !at_upper &&
    pos_known && !tx_req |-> ##[1:2] tx_byte[1:0] == 2'b01)
    else $error("bad lower code");
  a_pos_unknown: assert property ($fell(pos_known) && !tx_req |->
    ##[1:2] tx_byte[1:0] == 2'b11) else $error("bad unknown code");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule
bind bsbe_top bsbe_assertions bsbe_assertions_inst (.clk, .nrst,
  .mode_safe_a, .at_upper, .at_lower, .pos_known, .tx_ack, .tx_req,
  .tx_byte, .hreadyout, .hresp);
`default_nettype wire

// ===== dv/bsbe_bus_model.sv
// Far-side bus model taking status bytes
`timescale 1ns/100ps
`default_nettype none
module bsbe_bus_model (
  input wire logic clk,
  input wire logic tx_req,
  input wire logic [7:0] tx_byte,
  input wire logic slow,
  output logic tx_ack = 0,
  output logic [7:0] got,
  output logic [7:0] n_got = 0
);
  logic [2:0] w = 0;
  // One-cycle ack after a short or long wait
  always @(posedge clk) begin
    tx_ack <= 0;
    w <= tx_req && !tx_ack ? w + 1 : 0;
    if (tx_req && !tx_ack && w == (slow ? 4 : 1)) begin
      tx_ack <= 1;
      got <= tx_byte;
      n_got <= n_got + 1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/bsbe_top_test.sv
// Bench for the status byte encoder
`timescale 1ns/100ps
`default_nettype none
module bsbe_top_test;
  logic clk = 0, nrst = 0, slow = 0, hwrite = 0, hsel = 1, tx_ack, tx_req;
  logic mode_safe_a = 0, mode_safe_b = 0, mode_auto = 0, mode_sun = 0;
  logic at_upper = 0, at_lower = 0, pos_known = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] tx_byte, got, n_got, n_seen = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  int n_errors = 0, total_checks = 0;
  // Inputs {slow,a,b,auto,sun,upper,lower,known}, then expected byte
  logic [15:0] tbl [6] = '{16'h4321, 16'h2512, 16'h9108, 16'h0807,
    16'hff23, 16'h0301};
  wire hready = hreadyout;
  bsbe_top bsbe_top_inst (.clk(clk), .nrst(nrst),
    .mode_safe_a(mode_safe_a), .mode_safe_b(mode_safe_b),
    .mode_auto(mode_auto), .mode_sun(mode_sun), .at_upper(at_upper),
    .at_lower(at_lower), .pos_known(pos_known), .tx_ack(tx_ack),
    .tx_req(tx_req), .tx_byte(tx_byte), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  bsbe_bus_model bsbe_bus_model_inst (.clk, .tx_req, .tx_byte, .slow,
    .tx_ack, .got, .n_got);
  // Free-running clock
  initial forever #4 clk = ~clk;
  task close_out;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready or a delivered byte; a hang ends the run
  task tick(input bit tx);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((tx ? n_got === n_seen : hreadyout !== 1'b1) && k < 60);
    if (tx) n_seen = n_got;
    if (k == 60) begin
      n_errors++;
      close_out;
    end
  endtask
  task ahb(input logic wr, input logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    tick(0);
    htrans <= 2'h0;
    hwdata <= d;
    tick(0);
    q = hrdata;
  endtask
  // Main sequence; each input step changes the byte so it must go out
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    tick(1);
    chk(got, 8'h03);
    foreach (tbl[i]) begin
      {slow, mode_safe_a, mode_safe_b, mode_auto, mode_sun, at_upper,
        at_lower, pos_known} <= tbl[i][15:8];
      tick(1);
      chk(got, tbl[i][7:0]);
      ahb(0, 0, 0);
      chk(q[7:0], tbl[i][7:0]);
    end
    ahb(1, 0, 32'hff);
    ahb(0, 0, 0);
    chk(q[7:0], 8'h01);
    ahb(1, 32'h8, 32'h1);
    tick(1);
    chk(got, 8'h01);
    ahb(0, 32'h10, 0);
    chk(q[7:0], 8'h00);
    // Sending disabled: a change is held back, then goes out on enable
    ahb(1, 32'h4, 32'h0);
    ahb(0, 32'h4, 0);
    chk(q[7:0], 8'h00);
    mode_sun <= 1;
    repeat (10) @(posedge clk);
    chk(n_got, n_seen);
    ahb(0, 32'h8, 0);
    chk(q[7:0], 8'h00);
    ahb(0, 0, 0);
    chk(q[7:0], 8'h05);
    ahb(1, 32'h4, 32'h1);
    tick(1);
    chk(got, 8'h05);
    ahb(0, 32'h4, 0);
    chk(q[7:0], 8'h01);
    close_out;
  end
endmodule
`default_nettype wire
